// File: verification/ssc_pin_model.sv
/*
  Far-side model: strap pin wiring and external switch.
  Assumes strobes from ssc_top; wiring 1 ground, 2 battery, else open.
*/
module ssc_pin_model (
  input wire logic hs,
  input wire logic ls,
  input wire logic [1:0] wiring,
  input wire logic closed,
  output logic cmp,
  output logic sw_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ground answers the high strobe, battery the low one, open never
  assign cmp = (wiring == 2'h1) ? hs : ((wiring == 2'h2) ? ls : 1'b0);
  assign sw_cmp = closed;
endmodule : ssc_pin_model

// File: verification/ssc_top_properties.sv
/*
  Port checker of ssc_top.
  Assumes it is bound onto ssc_top and sees its ports by name.
*/
module ssc_props
  import ssc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic HIGH_SIDE_SENSE_STROBE,
  input wire logic LOW_SIDE_SENSE_STROBE,
  input wire logic LIN_FRAME_VALID,
  input wire logic SLEEP_ACTIVE,
  input wire logic BRIDGE_HIZ,
  input wire logic MOTOR_RUN
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------
  // helper logic
  // ---------------------------------------
  wire logic hs = HIGH_SIDE_SENSE_STROBE;
  wire logic ls = LOW_SIDE_SENSE_STROBE;
  int on_cnt;
  logic last_hs;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  // on-time count and last side; reset seeds high so low goes first
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      on_cnt <= 0;
      last_hs <= 1'b1;
    end
    else
    begin
      on_cnt <= (hs || ls) ? on_cnt + 1 : 0;
      last_hs <= hs ? 1'b1 : (ls ? 1'b0 : last_hs);
    end
  end
  // ---------------------------------------
  // properties
  // ---------------------------------------
  property p_excl; !(hs && ls); endproperty
  a_excl: assert property (p_excl) else $error("strobe overlap");
  property p_alt; ($rose(ls) || $rose(hs)) |-> ls == last_hs; endproperty
  a_alt: assert property (p_alt) else $error("strobe side repeated");
  property p_len; ($fell(ls) || $fell(hs)) |-> on_cnt == STROBE_ON_CYC; endproperty
  a_len: assert property (p_len) else $error("strobe length");
  property p_wait; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
  a_wait: assert property (p_wait) else $error("bus wait too long");
  property p_rst; $fell(RST) |-> (BRIDGE_HIZ && !MOTOR_RUN && !SLEEP_ACTIVE) [*8]; endproperty
  a_rst: assert property (p_rst) else $error("bridges not idle after reset");
  property p_wake; SLEEP_ACTIVE && LIN_FRAME_VALID |-> ##[1:3] !SLEEP_ACTIVE; endproperty
  a_wake: assert property (p_wake) else $error("no wake on frame");
  property p_hiz; $rose(SLEEP_ACTIVE) |-> ##[0:1] BRIDGE_HIZ; endproperty
  a_hiz: assert property (p_hiz) else $error("bridges live in sleep");
  property p_run; MOTOR_RUN |-> !BRIDGE_HIZ && !SLEEP_ACTIVE; endproperty
  a_run: assert property (p_run) else $error("run with bridges off");
endmodule : ssc_props

bind ssc_top ssc_props i_ssc_props (.*);

// File: verification/tb_ssc_top.sv
/*
  Self-checking bench of the stepper supervisory control block.
  Assumes ssc_top, ssc_pin_model and the bound checker.
*/
module tb_ssc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssc_pkg::*;
  localparam int SP = 6600;
  localparam int PW = 10;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, fv = 1'b0, tick = 1'b0;
  logic sq = 1'b0, rpc = 1'b0, step = 1'b0, stp = 1'b0, warn = 1'b0, dfct = 1'b0, shut = 1'b0;
  logic uv = 1'b0, loss = 1'b0, closed = 1'b0, cmp, swc, wreq, hs, ls, run, dir, decel, hiz, slp;
  logic [1:0] tinfo = 2'h0, wiring = 2'h0;
  logic [4:0] addr = 5'h00;
  logic [5:0] fid = 6'h00;
  logic [7:0] fd = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  ssc_resp_s resp;
  int n_errors = 0, checked = 0;
  ssc_top #(.STROBE_PER(SP), .FLOAT_WAIT(50), .PWRUP_WAIT(PW)) i_ssc_top (
    .REF_CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .STRAP_COMPARATOR_OUT(cmp), .HIGH_SIDE_SENSE_STROBE(hs), .LOW_SIDE_SENSE_STROBE(ls),
    .EXTERNAL_SWITCH_CMP(swc), .OVERHEAT_WARN_IN(warn), .OVERHEAT_SHUT_IN(shut),
    .ELEC_DEFECT_IN(dfct), .UNDERVOLT_IN(uv), .STEP_LOSS_IN(loss), .TEMP_INFO(tinfo),
    .LIN_FRAME_VALID(fv), .LIN_FRAME_ID(fid), .LIN_DATA0(fd), .LIN_BIT_TICK(tick),
    .STATUS_QUERY(sq), .READ_POS_CMD(rpc), .STEP_PULSE(step), .MOTION_STOPPED(stp),
    .MOTOR_RUN(run), .MOTOR_DIR(dir), .DECEL_REQ(decel), .BRIDGE_HIZ(hiz),
    .SLEEP_ACTIVE(slp), .RESP_FRAME(resp));
  ssc_pin_model i_ssc_pin_model (.hs(hs), .ls(ls), .wiring(wiring), .closed(closed), .cmp(cmp), .sw_cmp(swc));
  // ---------------------------------------
  // clock, shared tasks
  // ---------------------------------------
  always #5 clk = ~clk;
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  // one-cycle pulse: 0 step, 1 stopped, 2 read position, else status query
  task automatic pl(input int k);
    @(posedge clk);
    case (k)
      0: step <= 1'b1;
      1: stp <= 1'b1;
      2: rpc <= 1'b1;
      default: sq <= 1'b1;
    endcase
    @(posedge clk);
    {step, stp, rpc, sq} <= 4'h0;
    @(posedge clk);
  endtask : pl
  task automatic frame(input logic [5:0] id, input logic [7:0] d);
    @(posedge clk);
    fid <= id;
    fd <= d;
    fv <= 1'b1;
    @(posedge clk);
    fv <= 1'b0;
    cyc(3);
  endtask : frame
  // ---------------------------------------
  // scenarios
  // ---------------------------------------
  task automatic t_reset();
    chk(hiz, 1'b1);
    chk(resp, '0);
    cyc(PW + 3);
    chk(hiz, 1'b0);
    bus(0, REG_CTRL, 0);
    chk(q, 0);
    bus(1, 5'h18, 32'hffffffff);
    bus(0, 5'h18, 0);
    chk(q, 0);
    $display("reset test done");
  endtask : t_reset
  // wrap-sensitive targets around a start of -5 in both modes
  task automatic t_goto();
    logic [15:0] tg [5] = '{16'hfffb, 16'h0ffa, 16'h0ffc, 16'h7ffa, 16'h7ffc};
    logic mi [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic dr [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++)
    begin
      bus(1, REG_CTRL, {27'h0, mi[i], 4'h0});
      bus(1, REG_TARGET, {16'h0, tg[i]});
      bus(1, REG_CTRL, {27'h0, mi[i], 4'h1});
      cyc(3);
      chk(dir, dr[i]);
      if (i == 0)
      begin
        chk(run, 1'b1);
        repeat (5) pl(0);
        cyc(1);
        chk(run, 1'b0);
      end
    end
    bus(1, REG_CTRL, 32'h12);
    cyc(2);
    chk(decel, 1'b1);
    pl(1);
    cyc(1);
    chk(decel, 1'b0);
    bus(0, REG_POS, 0);
    chk(q, 32'hfffbfffb);
    $display("goto test done");
  endtask : t_goto
  // wiring changed only between strobes so the next two probes are whole
  task automatic t_strap();
    logic [1:0] wi [3] = '{2'h2, 2'h1, 2'h0};
    logic [2:0] st [3] = '{3'h4, 3'h2, 3'h1};
    logic sw [3] = '{1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++)
    begin
      while (hs || ls) @(posedge clk);
      wiring <= wi[i];
      closed <= sw[i];
      cyc(2 * SP + 20);
      bus(0, REG_STATUS, 0);
      chk({q[7], q[2:0]}, {sw[i], st[i]});
      pl(2);
      chk(resp.data1, {sw[i], 6'h00, st[i][2]});
      chk({resp.data2, resp.data3}, 16'hfffb);
    end
    chk({resp.data4, resp.checksum}, 16'h8003);
    // open strap outlives the float timer, so a move to safe position 0 starts
    cyc(60);
    chk(run, 1'b1);
    repeat (5) pl(0);
    bus(0, REG_POS, 0);
    chk(q, 0);
    $display("strap test done");
  endtask : t_strap
  task automatic t_sleep();
    bus(1, REG_CTRL, 32'h0);
    frame(6'h3c, 8'h00);
    chk(slp, 1'b0);
    bus(1, REG_CTRL, 32'h4);
    frame(6'h3c, 8'h01);
    chk(slp, 1'b0);
    frame(6'h3c, 8'h00);
    chk({slp, hiz}, 2'h3);
    frame(6'h01, 8'h55);
    chk(slp, 1'b0);
    @(posedge clk);
    tick <= 1'b1;
    cyc(25000);
    tick <= 1'b0;
    cyc(3);
    chk(slp, 1'b0);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    cyc(3);
    chk(slp, 1'b1);
    frame(6'h02, 8'h00);
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_flags();
    @(posedge clk);
    {warn, dfct, uv, loss} <= 4'hf;
    tinfo <= 2'h2;
    @(posedge clk);
    {dfct, uv, loss} <= 3'h0;
    cyc(10);
    pl(2);
    chk(resp.data4, 8'hf6);
    pl(3);
    pl(2);
    chk(resp.data4, 8'h06);
    warn <= 1'b0;
    cyc(20);
    pl(3);
    pl(2);
    chk(resp.data4, 8'h02);
    // shutdown flag holds the bridges off until a query below warning
    @(posedge clk);
    shut <= 1'b1;
    cyc(10);
    chk(hiz, 1'b1);
    shut <= 1'b0;
    cyc(10);
    chk(hiz, 1'b1);
    pl(3);
    cyc(3);
    chk(hiz, 1'b0);
    $display("flag test done");
  endtask : t_flags
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // watchdog sized above the sum of all waits
  initial
  begin
    cyc(100000);
    n_errors++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    t_reset();
    t_goto();
    t_strap();
    t_sleep();
    t_flags();
    tally_and_finish();
  end
endmodule : tb_ssc_top

// File: verilog/ssc_pkg.sv
/*
  Shared constants and types of the stepper supervisory control block.
  Assumes a single 100 MHz logic clock.
*/
package ssc_pkg;
  // -----------------------------------------
  // clock and timing
  // -----------------------------------------
  localparam int CLK_HZ = 100000000;
  localparam int CYC_PER_US = CLK_HZ / 1000000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int STROBE_US = 1024;
  localparam int STROBE_CYC = STROBE_US * CYC_PER_US;
  localparam int DEB_US = 32;
  // built from cycles per microsecond, the product with the clock rate overflows an int
  localparam int DEB_CYC = DEB_US * CYC_PER_US;
  localparam int STROBE_ON_CYC = 2 * DEB_CYC;
  localparam int FLOAT_MS = 64;
  localparam int FLOAT_CYC = FLOAT_MS * CYC_PER_MS;
  localparam int PWRUP_MS = 10;
  localparam int PWRUP_CYC = PWRUP_MS * CYC_PER_MS;
  localparam int SLEEP_SLOTS = 25000;
  // -----------------------------------------
  // register map, byte offsets
  // -----------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_TARGET = 5'h04;
  localparam logic [4:0] REG_POS = 5'h08;
  localparam logic [4:0] REG_RESP = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_CONFIG = 5'h14;
  localparam int CTRL_GOTO = 0;
  localparam int CTRL_HALT = 1;
  localparam int CTRL_SLEEP_ALLOW = 2;
  localparam int CTRL_SAFE_EN = 3;
  localparam int CTRL_MICRO = 4;
  localparam int CTRL_SAFE_GO = 5;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] TARGET_RST = 16'h0000;
  localparam logic [21:0] CONFIG_RST = 22'h000000;
  // -----------------------------------------
  // link constants and position range
  // -----------------------------------------
  localparam logic [5:0] SLEEP_FRAME_ID = 6'h3c;
  localparam logic [7:0] SLEEP_FRAME_DATA = 8'h00;
  localparam int HALF_POS_MSB = 12;
  // -----------------------------------------
  // types
  // -----------------------------------------
  typedef enum logic [2:0] {
    STRAP_FLOAT = 3'b001,
    STRAP_LOW = 3'b010,
    STRAP_HIGH = 3'b100
  } ssc_strap_e;
  typedef enum logic [5:0] {
    M_POWERUP = 6'b000001,
    M_IDLE = 6'b000010,
    M_MOVE = 6'b000100,
    M_HALT = 6'b001000,
    M_SLEEP = 6'b010000,
    M_SHUTDOWN = 6'b100000
  } ssc_mode_e;
  typedef struct packed {
    logic [7:0] data1;
    logic [7:0] data2;
    logic [7:0] data3;
    logic [7:0] data4;
    logic [7:0] checksum;
  } ssc_resp_s;
endpackage : ssc_pkg

// File: verilog/ssc_top.sv
/*
  Supervisory control of a bus-slave stepper positioner: strap and switch
  sensing, position bookkeeping, halt, sleep and thermal handling.
  Assumes the frame decoder, ramp generator and comparators are outside,
  and that same-clock inputs come from logic on REF_CLK.
*/

// -----------------------------------------
// synchroniser with stability filter
// -----------------------------------------
module ssc_sync_deb #(
  parameter int DEB = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic level
);
  import ssc_pkg::*;
  logic q1;
  logic q2;
  logic q3;
  logic [11:0] cnt;

  // three-stage synchroniser, first stage only feeds the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q1 <= 1'b0;
      q2 <= 1'b0;
      q3 <= 1'b0;
    end
    else
    begin
      q1 <= async_in;
      q2 <= q1;
      q3 <= q2;
    end
  end

  // level follows only after DEB agreeing cycles
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt <= 12'h000;
      level <= 1'b0;
    end
    else if (q2 != q3 || q3 == level)
      cnt <= 12'h000;
    else if (cnt == 12'(DEB - 1))
    begin
      level <= q3;
      cnt <= 12'h000;
    end
    else
      cnt <= cnt + 12'h001;
  end
endmodule : ssc_sync_deb

// -----------------------------------------
// top level
// -----------------------------------------
module ssc_top #(
  parameter int STROBE_PER = ssc_pkg::STROBE_CYC,
  parameter int FLOAT_WAIT = ssc_pkg::FLOAT_CYC,
  parameter int PWRUP_WAIT = ssc_pkg::PWRUP_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic STRAP_COMPARATOR_OUT,
  output logic HIGH_SIDE_SENSE_STROBE,
  output logic LOW_SIDE_SENSE_STROBE,
  input wire logic EXTERNAL_SWITCH_CMP,
  input wire logic OVERHEAT_WARN_IN,
  input wire logic OVERHEAT_SHUT_IN,
  input wire logic ELEC_DEFECT_IN,
  input wire logic UNDERVOLT_IN,
  input wire logic STEP_LOSS_IN,
  input wire logic [1:0] TEMP_INFO,
  input wire logic LIN_FRAME_VALID,
  input wire logic [5:0] LIN_FRAME_ID,
  input wire logic [7:0] LIN_DATA0,
  input wire logic LIN_BIT_TICK,
  input wire logic STATUS_QUERY,
  input wire logic READ_POS_CMD,
  input wire logic STEP_PULSE,
  input wire logic MOTION_STOPPED,
  output logic MOTOR_RUN,
  output logic MOTOR_DIR,
  output logic DECEL_REQ,
  output logic BRIDGE_HIZ,
  output logic SLEEP_ACTIVE,
  output ssc_pkg::ssc_resp_s RESP_FRAME
);
  import ssc_pkg::*;

  logic ack;
  logic wr_ok;
  logic [2:0] ctrl;
  logic [15:0] tgt_cmd;
  logic [21:0] cfg;
  logic strap_cmp;
  logic sw_cmp;
  logic warn_s;
  logic shut_s;
  logic shut_d;
  logic [23:0] per_cnt;
  logic strobe_on;
  logic lo_phase;
  logic eval;
  ssc_strap_e strap;
  logic [23:0] float_cnt;
  logic float_fired;
  logic safe_trig;
  logic switch_closed_flag;
  logic [15:0] pos_latched;
  logic [15:0] actual_position;
  logic [15:0] target_position;
  ssc_mode_e mode;
  logic [23:0] pw_cnt;
  logic sleep_pend;
  logic [14:0] slot_cnt;
  logic logic_supply_reset_flag;
  logic lost_steps_flag;
  logic electrical_defect_flag;
  logic undervoltage_stop_flag;
  logic overheat_shutdown_flag;
  logic overheat_warning_flag;
  logic micro;
  logic [6:0] node_addr;
  logic [7:0] flag_byte;
  logic [15:0] diff;
  logic dir_pos;
  logic arrived;
  logic goto_req;
  logic halt_req;
  logic safe_go;
  logic sleep_req;
  logic permit;
  logic query_clr;
  logic [31:0] rd_mux;

  // LIN classic checksum: inverted sum with carry wrap
  function automatic logic [7:0] lin_sum(input logic [31:0] d);
    logic [8:0] s;
    s = 9'h000;
    for (int i = 0; i < 4; i++)
    begin
      s = 9'({1'b0, s[7:0]} + {1'b0, d[8*i+:8]} + {8'h00, s[8]});
    end
    s = 9'({1'b0, s[7:0]} + {8'h00, s[8]});
    return ~s[7:0];
  endfunction : lin_sum

  // wrap to the range of the active stepping mode
  function automatic logic [15:0] wrapm(input logic m, input logic [15:0] x);
    return m ? x : {{3{x[HALF_POS_MSB]}}, x[HALF_POS_MSB:0]};
  endfunction : wrapm

  // -----------------------------------------
  // register bus slave
  // -----------------------------------------
  // one wait cycle per access keeps read data registered
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
  assign wr_ok = AVS_WRITE & ack;

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      ack <= 1'b0;
    else
      ack <= (AVS_READ | AVS_WRITE) & ~ack;
  end

  // stored control, command and config words
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ctrl <= CTRL_RST;
      tgt_cmd <= TARGET_RST;
      cfg <= CONFIG_RST;
    end
    else if (wr_ok)
    begin
      if (AVS_ADDRESS == REG_CTRL)
        ctrl <= AVS_WRITEDATA[CTRL_MICRO:CTRL_SLEEP_ALLOW];
      if (AVS_ADDRESS == REG_TARGET)
        tgt_cmd <= AVS_WRITEDATA[15:0];
      if (AVS_ADDRESS == REG_CONFIG)
        cfg <= AVS_WRITEDATA[21:0];
    end
  end

  // command pulses taken from the accepted control write, safe go also from the float timer trigger
  assign goto_req = wr_ok && AVS_ADDRESS == REG_CTRL && AVS_WRITEDATA[CTRL_GOTO];
  assign halt_req = wr_ok && AVS_ADDRESS == REG_CTRL && AVS_WRITEDATA[CTRL_HALT];
  assign safe_go = safe_trig | (wr_ok && AVS_ADDRESS == REG_CTRL && AVS_WRITEDATA[CTRL_SAFE_GO]);
  assign micro = ctrl[CTRL_MICRO - CTRL_SLEEP_ALLOW];

  // read multiplexer, unmapped offsets read zero
  always_comb
  begin
    case (AVS_ADDRESS)
      REG_CTRL: rd_mux = {27'h0000000, ctrl, 2'b00};
      REG_TARGET: rd_mux = {16'h0000, tgt_cmd};
      REG_POS: rd_mux = {target_position, actual_position};
      REG_RESP: rd_mux = RESP_FRAME[39:8];
      REG_STATUS: rd_mux = {flag_byte, 2'b00, mode, 8'h00, switch_closed_flag, float_fired, 3'b000, strap};
      REG_CONFIG: rd_mux = {10'h000, cfg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      AVS_READDATA <= 32'h00000000;
    else if (AVS_READ & ~ack)
      AVS_READDATA <= rd_mux;
  end

  // -----------------------------------------
  // input synchronisers
  // -----------------------------------------
  ssc_sync_deb #(.DEB(DEB_CYC)) u_strap (
    .clk(REF_CLK), .rst(RST), .async_in(STRAP_COMPARATOR_OUT), .level(strap_cmp)
  );
  ssc_sync_deb #(.DEB(DEB_CYC)) u_switch (
    .clk(REF_CLK), .rst(RST), .async_in(EXTERNAL_SWITCH_CMP), .level(sw_cmp)
  );
  ssc_sync_deb #(.DEB(1)) u_warn (
    .clk(REF_CLK), .rst(RST), .async_in(OVERHEAT_WARN_IN), .level(warn_s)
  );
  ssc_sync_deb #(.DEB(1)) u_shut (
    .clk(REF_CLK), .rst(RST), .async_in(OVERHEAT_SHUT_IN), .level(shut_s)
  );

  // -----------------------------------------
  // strobe sequencer
  // -----------------------------------------
  // strobe held twice the filter time so the filter settles inside it
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      per_cnt <= 24'h000000;
      strobe_on <= 1'b0;
      lo_phase <= 1'b1;
    end
    else
    begin
      strobe_on <= per_cnt < 24'(STROBE_ON_CYC);
      if (per_cnt == 24'(STROBE_PER - 1))
      begin
        per_cnt <= 24'h000000;
        lo_phase <= ~lo_phase;
      end
      else
        per_cnt <= per_cnt + 24'h000001;
    end
  end

  assign eval = per_cnt == 24'(STROBE_ON_CYC);
  assign HIGH_SIDE_SENSE_STROBE = strobe_on & ~lo_phase;
  assign LOW_SIDE_SENSE_STROBE = strobe_on & lo_phase;

  // -----------------------------------------
  // strap state machine
  // -----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      strap <= STRAP_FLOAT;
    else if (eval)
    begin
      case (strap)
        STRAP_FLOAT: strap <= strap_cmp ? (lo_phase ? STRAP_HIGH : STRAP_LOW) : STRAP_FLOAT;
        STRAP_LOW:
          if (lo_phase)
            strap <= strap_cmp ? STRAP_HIGH : STRAP_LOW;
          else
            strap <= strap_cmp ? STRAP_LOW : STRAP_FLOAT;
        STRAP_HIGH:
          if (lo_phase)
            strap <= strap_cmp ? STRAP_HIGH : STRAP_FLOAT;
          else
            strap <= strap_cmp ? STRAP_LOW : STRAP_HIGH;
        default: strap <= STRAP_FLOAT;
      endcase
    end
  end

  // float indication kept apart from the address bit
  assign node_addr = {cfg[21:16], strap == STRAP_HIGH};

  // float persistence timer, one trigger per float episode
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      float_cnt <= 24'h000000;
      float_fired <= 1'b0;
      safe_trig <= 1'b0;
    end
    else
    begin
      safe_trig <= 1'b0;
      if (strap != STRAP_FLOAT)
      begin
        float_cnt <= 24'h000000;
        float_fired <= 1'b0;
      end
      else if (!float_fired)
      begin
        if (float_cnt == 24'(FLOAT_WAIT - 1))
        begin
          float_fired <= 1'b1;
          safe_trig <= 1'b1;
        end
        else
          float_cnt <= float_cnt + 24'h000001;
      end
    end
  end

  // -----------------------------------------
  // switch and position snapshot
  // -----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      switch_closed_flag <= 1'b0;
      pos_latched <= 16'h0000;
    end
    else if (eval)
    begin
      switch_closed_flag <= sw_cmp;
      pos_latched <= actual_position;
    end
  end

  // -----------------------------------------
  // position and direction
  // -----------------------------------------
  // shortest path falls out of the wrapped difference sign
  assign diff = wrapm(micro, 16'(target_position - actual_position));
  assign dir_pos = ~diff[15];
  assign arrived = diff == 16'h0000;

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      actual_position <= 16'h0000;
    else if (STEP_PULSE && (mode == M_MOVE || mode == M_HALT))
      actual_position <= wrapm(micro, MOTOR_DIR ? 16'(actual_position + 16'h0001)
                                            : 16'(actual_position - 16'h0001));
  end

  assign permit = ~overheat_shutdown_flag & ~electrical_defect_flag;

  // target follows commands, safe position and halt completion
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      target_position <= 16'h0000;
    else if (mode == M_HALT && MOTION_STOPPED)
      target_position <= actual_position;
    else if (mode == M_IDLE || mode == M_MOVE)
    begin
      if ((safe_go && permit) || (mode == M_MOVE && sleep_req && ctrl[CTRL_SAFE_EN - CTRL_SLEEP_ALLOW]))
        target_position <= wrapm(micro, cfg[15:0]);
      else if (goto_req && permit && !sleep_pend)
        target_position <= wrapm(micro, tgt_cmd);
    end
  end

  // -----------------------------------------
  // sleep requests
  // -----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      slot_cnt <= 15'h0000;
    else if (LIN_FRAME_VALID || mode == M_SLEEP)
      slot_cnt <= 15'h0000;
    else if (LIN_BIT_TICK && slot_cnt != 15'(SLEEP_SLOTS))
      slot_cnt <= slot_cnt + 15'h0001;
  end

  // silence must exceed the slot count, hence one extra tick
  assign sleep_req = ctrl[0] && ((LIN_FRAME_VALID && LIN_FRAME_ID == SLEEP_FRAME_ID
                     && LIN_DATA0 == SLEEP_FRAME_DATA)
                     || (LIN_BIT_TICK && slot_cnt == 15'(SLEEP_SLOTS)));

  // -----------------------------------------
  // operating mode
  // -----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      mode <= M_POWERUP;
      pw_cnt <= 24'h000000;
      sleep_pend <= 1'b0;
    end
    else
    begin
      case (mode)
        M_POWERUP:
          if (pw_cnt == 24'(PWRUP_WAIT - 1))
            mode <= M_IDLE;
          else
            pw_cnt <= pw_cnt + 24'h000001;
        M_IDLE:
          if (overheat_shutdown_flag)
            mode <= M_SHUTDOWN;
          else if (sleep_req)
            mode <= M_SLEEP;
          else if ((goto_req || safe_go) && permit)
            mode <= M_MOVE;
        M_MOVE:
          if (shut_s && !shut_d || overheat_shutdown_flag || halt_req)
            mode <= M_HALT;
          else if (sleep_req && !ctrl[CTRL_SAFE_EN - CTRL_SLEEP_ALLOW])
          begin
            mode <= M_HALT;
            sleep_pend <= 1'b1;
          end
          else if (sleep_req)
            sleep_pend <= 1'b1;
          else if (arrived)
          begin
            mode <= sleep_pend ? M_SLEEP : M_IDLE;
            sleep_pend <= 1'b0;
          end
        M_HALT:
          if (MOTION_STOPPED)
          begin
            mode <= overheat_shutdown_flag ? M_SHUTDOWN : (sleep_pend ? M_SLEEP : M_IDLE);
            sleep_pend <= 1'b0;
          end
        M_SLEEP:
          if (LIN_FRAME_VALID)
            mode <= M_IDLE;
        M_SHUTDOWN:
          if (!overheat_shutdown_flag)
            mode <= M_IDLE;
        default: mode <= M_POWERUP;
      endcase
    end
  end

  // registered motor and power outputs
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      MOTOR_RUN <= 1'b0;
      MOTOR_DIR <= 1'b1;
      DECEL_REQ <= 1'b0;
      BRIDGE_HIZ <= 1'b1;
      SLEEP_ACTIVE <= 1'b0;
    end
    else
    begin
      MOTOR_RUN <= mode == M_MOVE && !arrived;
      if (mode == M_MOVE)
        MOTOR_DIR <= dir_pos;
      DECEL_REQ <= mode == M_HALT;
      BRIDGE_HIZ <= mode == M_POWERUP || mode == M_SLEEP || mode == M_SHUTDOWN;
      SLEEP_ACTIVE <= mode == M_SLEEP;
    end
  end

  // -----------------------------------------
  // status flags
  // -----------------------------------------
  // set always beats a same-cycle query clear
  assign query_clr = STATUS_QUERY & ~warn_s;

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      logic_supply_reset_flag <= 1'b1;
      lost_steps_flag <= 1'b0;
      electrical_defect_flag <= 1'b0;
      undervoltage_stop_flag <= 1'b0;
      overheat_shutdown_flag <= 1'b0;
      overheat_warning_flag <= 1'b0;
      shut_d <= 1'b0;
    end
    else
    begin
      shut_d <= shut_s;
      logic_supply_reset_flag <= logic_supply_reset_flag & ~STATUS_QUERY;
      lost_steps_flag <= STEP_LOSS_IN | (lost_steps_flag & ~STATUS_QUERY);
      electrical_defect_flag <= ELEC_DEFECT_IN | (electrical_defect_flag & ~STATUS_QUERY);
      undervoltage_stop_flag <= UNDERVOLT_IN | (undervoltage_stop_flag & ~STATUS_QUERY);
      overheat_shutdown_flag <= shut_s | (overheat_shutdown_flag & ~query_clr);
      overheat_warning_flag <= warn_s | (overheat_warning_flag & ~query_clr);
    end
  end

  assign flag_byte = {logic_supply_reset_flag, lost_steps_flag, electrical_defect_flag,
                      undervoltage_stop_flag, overheat_shutdown_flag, overheat_warning_flag,
                      TEMP_INFO};

  // -----------------------------------------
  // read-position response
  // -----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      RESP_FRAME <= '0;
    else if (READ_POS_CMD)
    begin
      RESP_FRAME.data1 <= {switch_closed_flag, node_addr};
      RESP_FRAME.data2 <= pos_latched[15:8];
      RESP_FRAME.data3 <= pos_latched[7:0];
      RESP_FRAME.data4 <= flag_byte;
      RESP_FRAME.checksum <= lin_sum({flag_byte, pos_latched[7:0], pos_latched[15:8],
                                      switch_closed_flag, node_addr});
    end
  end
endmodule : ssc_top
